// ===== ckpm_pkg.sv
package ckpm_pkg;

	localparam int          ADDR_W         = 32;
	localparam int          DATA_W         = 32;
	localparam logic [31:0] ADDR_POW_KEY1  = 32'hFFFF0404;
	localparam logic [31:0] ADDR_POW_CFG   = 32'hFFFF0408;
	localparam logic [31:0] ADDR_POW_KEY2  = 32'hFFFF040C;
	localparam logic [31:0] ADDR_CLK_KEY1  = 32'hFFFF0410;
	localparam logic [31:0] ADDR_CLK_CFG   = 32'hFFFF0414;
	localparam logic [31:0] ADDR_CLK_KEY2  = 32'hFFFF0418;
	localparam logic [31:0] ADDR_IRQ_STAT  = 32'hFFFF0420;
	localparam logic [31:0] ADDR_IRQ_MASK  = 32'hFFFF0424;
	localparam logic [31:0] ADDR_STATUS    = 32'hFFFF0428;

	localparam logic [15:0] CLK_KEY1_VAL   = 16'h00AA;
	localparam logic [15:0] CLK_KEY2_VAL   = 16'h0055;
	localparam logic [15:0] POW_KEY1_VAL   = 16'h0001;
	localparam logic [15:0] POW_KEY2_VAL   = 16'h00F4;

	localparam logic [7:0]  CLK_CFG_RST    = 8'h21;
	localparam logic [7:0]  POW_CFG_RST    = 8'h03;
	localparam logic [7:0]  CLK_CFG_MASK   = 8'h23;
	localparam logic [7:0]  POW_CFG_MASK   = 8'h77;
	localparam int          REF_SEL_BIT    = 5;
	localparam int          SRC_LSB        = 0;
	localparam int          MODE_LSB       = 4;
	localparam int          DIV_LSB        = 0;

	localparam logic [1:0]  SRC_PLL        = 2'h1;
	localparam logic [1:0]  SRC_EXT        = 2'h3;
	localparam logic [2:0]  MODE_ACTIVE    = 3'h0;
	localparam logic [2:0]  MODE_PAUSE     = 3'h1;
	localparam logic [2:0]  MODE_NAP       = 3'h2;
	localparam logic [2:0]  MODE_SLEEP     = 3'h3;
	localparam logic [2:0]  MODE_STOP      = 3'h4;

	localparam int          RUN_CORE       = 4;
	localparam int          RUN_PERIPH     = 3;
	localparam int          RUN_PLL        = 2;
	localparam int          RUN_XTAL       = 1;
	localparam int          RUN_EXT_IRQ    = 0;
	localparam logic [10:0] PLL_MULT       = 11'd1275;

	localparam int          IRQ_W          = 3;
	localparam int          IRQ_LOCK       = 0;
	localparam int          IRQ_WAKE       = 1;
	localparam int          IRQ_KEY        = 2;
	localparam int          ST_LOCK        = 0;
	localparam int          ST_SRC_LSB     = 1;
	localparam int          ST_REF         = 3;
	localparam int          ST_WAKE        = 4;
	localparam int          ST_CORE        = 5;

	localparam int          CLK_MHZ        = 200;
	localparam int          WAKE_FAST_NS   = 24;
	localparam int          WAKE_FAST_CYC  = (WAKE_FAST_NS * CLK_MHZ + 999) / 1000;
	localparam real         SLEEP_WAKE_MS  = 1.58;
	localparam real         STOP_WAKE_MS   = 1.7;
	localparam int          SLEEP_WAKE_DEF = int'($ceil(SLEEP_WAKE_MS * 1000.0 * CLK_MHZ));
	localparam int          STOP_WAKE_DEF  = int'($ceil(STOP_WAKE_MS * 1000.0 * CLK_MHZ));
	localparam int          WAKE_CNT_W     = 19;
	localparam int          DIV_CNT_W      = 7;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_OPEN,
		KEY_HELD
	} ckpm_key_t;

endpackage

// ===== ckpm_sync.sv
`timescale 1ns/10ps
// three stage synchroniser; output moves only when stages two and three agree
module ckpm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ckpm_sync_st_t;

	ckpm_sync_st_t s_q;
	ckpm_sync_st_t s_d;

	always_comb begin
		s_d    = s_q;
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < W; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.q[i] = s_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.q;

endmodule

// ===== ckpm_ctrl.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module ckpm_ctrl
	import ckpm_pkg::*;
#(
	parameter logic [ckpm_pkg::WAKE_CNT_W-1:0] SLEEP_WAKE_CYC =
		ckpm_pkg::WAKE_CNT_W'(ckpm_pkg::SLEEP_WAKE_DEF),
	parameter logic [ckpm_pkg::WAKE_CNT_W-1:0] STOP_WAKE_CYC  =
		ckpm_pkg::WAKE_CNT_W'(ckpm_pkg::STOP_WAKE_DEF)
) (
	input  wire logic                        clk_sys,
	input  wire logic                        srst,
	input  wire logic [ckpm_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ckpm_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [ckpm_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                        pll_lock,
	input  wire logic [3:0]                  external_interrupt_lines,
	input  wire logic                        wakeup_timer_irq,
	input  wire logic                        irq_pending_any,
	output logic                             core_clk_en,
	output logic                             core_run,
	output logic                             periph_run,
	output logic                             pll_run,
	output logic                             xtal_timer_run,
	output logic                             ext_irq_run,
	output logic                             ext_clk_select,
	output logic                             pll_ref_internal,
	output logic      [10:0]                 pll_multiplier,
	output logic                             pll_irq_req,
	output logic                             irq
);
	import ckpm_pkg::*;

	typedef struct packed {
		ckpm_key_t                 clk_key;
		ckpm_key_t                 pow_key;
		logic [7:0]                clk_pend;
		logic [7:0]                pow_pend;
		logic [7:0]                clk_cfg;
		logic [7:0]                pow_cfg;
		logic [1:0]                src_applied;
		logic                      ref_applied;
		logic [4:0]                runs;
		logic                      wake_busy;
		logic [WAKE_CNT_W-1:0]     wake_cnt;
		logic [DIV_CNT_W-1:0]      div_cnt;
		logic                      core_en;
		logic                      lock_prev;
		logic [IRQ_W-1:0]          irq_stat;
		logic [IRQ_W-1:0]          irq_mask;
		logic [DATA_W-1:0]         rdata;
	} ckpm_state_t;

	ckpm_state_t s_q;
	ckpm_state_t s_d;

	logic       lock_s;
	logic [3:0] ext_irq_s;

	// lock comes from the analog pll and the irq lines from pins, so both
	// are filtered before any decision is made on them
	ckpm_sync #(
		.W (5)
	) u_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.din     ({pll_lock, external_interrupt_lines}),
		.dout    ({lock_s, ext_irq_s})
	);

	function automatic ckpm_key_t key_next(
		input ckpm_key_t st,
		input logic      wr,
		input logic      key1_ok,
		input logic      reg_hit
	);
		ckpm_key_t nx;
		nx = st;
		if (wr) begin
			if (key1_ok) begin
				nx = KEY_OPEN;
			end else if (st == KEY_OPEN && reg_hit) begin
				nx = KEY_HELD;
			end else begin
				nx = KEY_IDLE;
			end
		end
		return nx;
	endfunction

	function automatic logic [4:0] mode_runs(input logic [2:0] mode);
		logic [4:0] r;
		r = '1;
		unique case (mode)
			MODE_ACTIVE: r = 5'h1F;
			MODE_PAUSE:  r = 5'h0F;
			MODE_NAP:    r = 5'h07;
			MODE_SLEEP:  r = 5'h03;
			MODE_STOP:   r = 5'h01;
			// reserved codes keep every domain running rather than risk a hang
			default:     r = 5'h1F;
		endcase
		return r;
	endfunction

	logic                  clk_k1;
	logic                  clk_k2;
	logic                  clk_hit;
	logic                  pow_k1;
	logic                  pow_k2;
	logic                  pow_hit;
	logic                  clk_commit;
	logic                  pow_commit;
	logic                  key_fault;
	logic [2:0]            mode;
	logic [2:0]            div;
	logic [4:0]            runs;
	logic                  wake_req;
	logic                  low_power;
	logic [WAKE_CNT_W-1:0] wake_len;
	logic [DIV_CNT_W-1:0]  div_mask;
	logic [IRQ_W-1:0]      irq_set;
	logic [IRQ_W-1:0]      irq_clr;
	logic [7:0]            pow_next;
	logic [DATA_W-1:0]     status;

	always_comb begin
		s_d = s_q;

		// key and protected register decode
		clk_k1  = reg_addr == ADDR_CLK_KEY1 && reg_wdata[15:0] == CLK_KEY1_VAL;
		clk_k2  = reg_addr == ADDR_CLK_KEY2 && reg_wdata[15:0] == CLK_KEY2_VAL;
		clk_hit = reg_addr == ADDR_CLK_CFG;
		pow_k1  = reg_addr == ADDR_POW_KEY1 && reg_wdata[15:0] == POW_KEY1_VAL;
		pow_k2  = reg_addr == ADDR_POW_KEY2 && reg_wdata[15:0] == POW_KEY2_VAL;
		pow_hit = reg_addr == ADDR_POW_CFG;

		clk_commit = reg_wr && s_q.clk_key == KEY_HELD && clk_k2;
		pow_commit = reg_wr && s_q.pow_key == KEY_HELD && pow_k2;
		// a config write outside an open sequence, or a held sequence not closed by key 2, raises the key fault flag
		key_fault  = reg_wr && ((clk_hit && s_q.clk_key != KEY_OPEN)
			|| (s_q.clk_key == KEY_HELD && !clk_k2)
			|| (pow_hit && s_q.pow_key != KEY_OPEN)
			|| (s_q.pow_key == KEY_HELD && !pow_k2));

		s_d.clk_key = key_next(s_q.clk_key, reg_wr, clk_k1, clk_hit);
		s_d.pow_key = key_next(s_q.pow_key, reg_wr, pow_k1, pow_hit);
		if (reg_wr && s_q.clk_key == KEY_OPEN && clk_hit) begin
			s_d.clk_pend = reg_wdata[7:0] & CLK_CFG_MASK;
		end
		if (reg_wr && s_q.pow_key == KEY_OPEN && pow_hit) begin
			s_d.pow_pend = reg_wdata[7:0] & POW_CFG_MASK;
		end
		if (clk_commit) begin
			s_d.clk_cfg = s_q.clk_pend;
		end

		mode = s_q.pow_cfg[MODE_LSB +: 3];
		div  = s_q.pow_cfg[DIV_LSB +: 3];
		runs = mode_runs(mode);

		// wake sources depend on how deep the part sleeps
		unique case (mode)
			MODE_PAUSE,
			MODE_NAP:   wake_req = irq_pending_any;
			MODE_SLEEP: wake_req = |ext_irq_s || wakeup_timer_irq;
			MODE_STOP:  wake_req = |ext_irq_s;
			default:    wake_req = 1'b0;
		endcase
		low_power = runs != 5'h1F;

		unique case (mode)
			MODE_SLEEP: wake_len = SLEEP_WAKE_CYC;
			MODE_STOP:  wake_len = STOP_WAKE_CYC;
			default:    wake_len = WAKE_CNT_W'(WAKE_FAST_CYC) << div;
		endcase

		irq_set  = '0;
		pow_next = s_q.pow_cfg;
		if (!s_q.wake_busy && low_power && wake_req) begin
			s_d.wake_busy = 1'b1;
			s_d.wake_cnt  = wake_len;
		end else if (s_q.wake_busy) begin
			s_d.wake_cnt = s_q.wake_cnt - WAKE_CNT_W'(1);
			if (s_q.wake_cnt <= WAKE_CNT_W'(1)) begin
				s_d.wake_busy = 1'b0;
				pow_next[MODE_LSB +: 3] = MODE_ACTIVE;
				irq_set[IRQ_WAKE] = 1'b1;
			end
		end
		// a fresh software setting outranks a wake that ends in the same cycle
		if (pow_commit) begin
			pow_next      = s_q.pow_pend;
			s_d.wake_busy = 1'b0;
		end
		s_d.pow_cfg = pow_next;
		s_d.runs    = mode_runs(pow_next[MODE_LSB +: 3]);

		// source switch is deferred to nap so the core never sees a glitchy change
		if (mode == MODE_NAP) begin
			if (s_q.clk_cfg[SRC_LSB +: 2] == SRC_PLL || s_q.clk_cfg[SRC_LSB +: 2] == SRC_EXT) begin
				s_d.src_applied = s_q.clk_cfg[SRC_LSB +: 2];
			end
			s_d.ref_applied = s_q.clk_cfg[REF_SEL_BIT];
		end

		// core enable pulses once every two to the divider cycles
		s_d.div_cnt = s_q.div_cnt + DIV_CNT_W'(1);
		div_mask    = DIV_CNT_W'((8'h01 << div) - 8'h01);
		s_d.core_en = runs[RUN_CORE] && lock_s && ((s_q.div_cnt & div_mask) == '0);

		// lock loss is only meaningful while the pll is powered
		s_d.lock_prev = lock_s;
		if (s_q.lock_prev && !lock_s && runs[RUN_PLL]) begin
			irq_set[IRQ_LOCK] = 1'b1;
		end
		irq_set[IRQ_KEY] = key_fault;

		irq_clr = '0;
		if (reg_wr && reg_addr == ADDR_IRQ_STAT) begin
			irq_clr = reg_wdata[IRQ_W-1:0];
		end
		if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
			s_d.irq_mask = reg_wdata[IRQ_W-1:0];
		end
		// set wins over a clear in the same cycle
		s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;

		status = '0;
		status[ST_LOCK] = lock_s;
		status[ST_SRC_LSB +: 2] = s_q.src_applied;
		status[ST_REF] = s_q.ref_applied;
		status[ST_WAKE] = s_q.wake_busy;
		status[ST_CORE] = s_q.runs[RUN_CORE];

		s_d.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CLK_CFG:  s_d.rdata = DATA_W'(s_q.clk_cfg);
				ADDR_POW_CFG:  s_d.rdata = DATA_W'(s_q.pow_cfg);
				ADDR_IRQ_STAT: s_d.rdata = DATA_W'(s_q.irq_stat);
				ADDR_IRQ_MASK: s_d.rdata = DATA_W'(s_q.irq_mask);
				ADDR_STATUS:   s_d.rdata = status;
				default:       s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_q             <= '0;
			s_q.clk_key     <= KEY_IDLE;
			s_q.pow_key     <= KEY_IDLE;
			s_q.clk_cfg     <= CLK_CFG_RST;
			s_q.pow_cfg     <= POW_CFG_RST;
			s_q.src_applied <= CLK_CFG_RST[SRC_LSB +: 2];
			s_q.ref_applied <= CLK_CFG_RST[REF_SEL_BIT];
			s_q.runs        <= mode_runs(POW_CFG_RST[MODE_LSB +: 3]);
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata        = s_q.rdata;
	assign core_clk_en      = s_q.core_en;
	assign core_run         = s_q.runs[RUN_CORE];
	assign periph_run       = s_q.runs[RUN_PERIPH];
	assign pll_run          = s_q.runs[RUN_PLL];
	assign xtal_timer_run   = s_q.runs[RUN_XTAL];
	assign ext_irq_run      = s_q.runs[RUN_EXT_IRQ];
	assign ext_clk_select   = s_q.src_applied == SRC_EXT;
	assign pll_ref_internal = s_q.ref_applied;
	assign pll_multiplier   = PLL_MULT;
	// held back until lock is back so the handler runs on a stable clock
	assign pll_irq_req      = s_q.irq_stat[IRQ_LOCK] && lock_s;
	assign irq              = |(s_q.irq_stat & s_q.irq_mask & {{(IRQ_W-1){1'b1}}, lock_s});

endmodule

// ===== ckpm_ctrl_asserts.sv
`timescale 1ns/10ps
module ckpm_ctrl_asserts
	import ckpm_pkg::*;
(
	input wire logic                        clk_sys,
	input wire logic                        srst,
	input wire logic [ckpm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ckpm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                        reg_wr,
	input wire logic                        pll_lock,
	input wire logic                        core_clk_en,
	input wire logic                        core_run,
	input wire logic                        periph_run,
	input wire logic                        pll_run,
	input wire logic                        xtal_timer_run,
	input wire logic                        ext_irq_run,
	input wire logic                        ext_clk_select,
	input wire logic                        pll_ref_internal,
	input wire logic [10:0]                 pll_multiplier,
	input wire logic                        pll_irq_req
);
	import ckpm_pkg::*;
	logic       pk1;
	logic       pcf;
	logic       pk2;
	logic [2:0] mode_q;
	assign pk1 = reg_wr && reg_addr == ADDR_POW_KEY1 && reg_wdata[15:0] == POW_KEY1_VAL;
	assign pcf = reg_wr && reg_addr == ADDR_POW_CFG;
	assign pk2 = reg_wr && reg_addr == ADDR_POW_KEY2 && reg_wdata[15:0] == POW_KEY2_VAL;
	// last mode value offered, whether or not the keys accept it
	always_ff @(posedge clk_sys)
		if (pcf)
			mode_q <= reg_wdata[6:4];
	function automatic logic [3:0] run_of(input logic [2:0] m);
		case (m)
			MODE_PAUSE: return 4'h7;
			MODE_NAP:   return 4'h3;
			MODE_SLEEP: return 4'h1;
			MODE_STOP:  return 4'h0;
			default:    return 4'hF;
		endcase
	endfunction
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_pow_commit;
		pk1 ##1 pcf ##1 pk2;
	endsequence
	sequence s_pow_bare;
		!pk1 ##1 pcf;
	endsequence
	property p_pow_commit;
		s_pow_commit |=> {core_run, periph_run, pll_run, xtal_timer_run} == run_of(mode_q);
	endproperty
	property p_pow_discard;
		s_pow_bare |=> ##1 !$fell(core_run) && !$fell(periph_run) && !$fell(pll_run);
	endproperty
	property p_lock_halt;
		!pll_lock [*6] |-> !core_clk_en;
	endproperty
	property p_lock_irq;
		!pll_lock [*6] |-> !pll_irq_req;
	endproperty
	property p_domains;
		(periph_run || !core_run) && (pll_run || !periph_run) && (xtal_timer_run || !pll_run);
	endproperty
	property p_ext_irq_on;
		ext_irq_run;
	endproperty
	property p_src_nap;
		$changed(ext_clk_select) || $changed(pll_ref_internal) |-> $past(pll_run && !periph_run);
	endproperty
	property p_reset_src;
		$fell(srst) |-> pll_ref_internal && !ext_clk_select && core_run;
	endproperty
	property p_mult;
		pll_multiplier == PLL_MULT;
	endproperty
	a_pow_commit:  assert property (p_pow_commit)  else $error("power commit gave wrong domains");
	a_pow_discard: assert property (p_pow_discard) else $error("unkeyed power write took effect");
	a_lock_halt:   assert property (p_lock_halt)   else $error("core clock runs without lock");
	a_lock_irq:    assert property (p_lock_irq)    else $error("lock request served while unlocked");
	a_domains:     assert property (p_domains)     else $error("domain run levels out of order");
	a_ext_irq_on:  assert property (p_ext_irq_on)  else $error("external interrupt domain stopped");
	a_src_nap:     assert property (p_src_nap)     else $error("source applied outside nap");
	a_reset_src:   assert property (p_reset_src)   else $error("reset source wrong");
	a_mult:        assert property (p_mult)        else $error("multiplier wrong");
endmodule

// ===== ckpm_ctrl_tb.sv
`timescale 1ns/10ps
module ckpm_ctrl_tb;
	import ckpm_pkg::*;
	localparam int SLP = 20;
	localparam int STP = 30;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        pll_lock = 1'b1;
	logic [3:0]  ext_lines = 4'h0;
	logic        wake_tmr = 1'b0;
	logic        pend = 1'b0;
	logic        core_clk_en, core_run, periph_run, pll_run, xtal_timer_run, ext_irq_run;
	logic        ext_clk_select, pll_ref_internal, pll_irq_req, irq;
	logic [10:0] mult;
	int          miscompares = 0;
	int          n_checks = 0;
	int          cyc = 0;
	ckpm_ctrl #(
		.SLEEP_WAKE_CYC(19'(SLP)),
		.STOP_WAKE_CYC (19'(STP))
	) ckpm_ctrl_inst (
		.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pll_lock,
		.external_interrupt_lines(ext_lines), .wakeup_timer_irq(wake_tmr), .irq_pending_any(pend),
		.core_clk_en, .core_run, .periph_run, .pll_run, .xtal_timer_run, .ext_irq_run,
		.ext_clk_select, .pll_ref_internal, .pll_multiplier(mult), .pll_irq_req, .irq
	);
	always #2.5 clk_sys = ~clk_sys;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// a hung wake loop must still reach the verdict
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic idle(input int n);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, what);
	endtask
	task automatic prot(input logic [31:0] ka, kv, ca, cv, kb, kw);
		wr(ka, kv);
		wr(ca, cv);
		wr(kb, kw);
		idle(3);
	endtask
	task automatic pow(input logic [31:0] v);
		prot(ADDR_POW_KEY1, 32'(POW_KEY1_VAL), ADDR_POW_CFG, v, ADDR_POW_KEY2, 32'(POW_KEY2_VAL));
	endtask
	task automatic clkc(input logic [31:0] v);
		prot(ADDR_CLK_KEY1, 32'(CLK_KEY1_VAL), ADDR_CLK_CFG, v, ADDR_CLK_KEY2, 32'(CLK_KEY2_VAL));
	endtask
	task automatic cnt_en(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			if (core_clk_en === 1'b1)
				c++;
		end
	endtask
	task automatic wake_by(input int s, input int lim);
		int n;
		n = 0;
		@(posedge clk_sys);
		if (s == 5)
			pend <= 1'b1;
		else if (s == 4)
			wake_tmr <= 1'b1;
		else
			ext_lines[s] <= 1'b1;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (core_run !== 1'b1 && n < 100);
		chk(32'(n >= lim && n <= lim + 8), 32'h1, "wake delay");
		@(posedge clk_sys);
		pend <= 1'b0;
		wake_tmr <= 1'b0;
		ext_lines <= 4'h0;
	endtask
	task automatic t_reset;
		rd(ADDR_CLK_CFG, 32'(CLK_CFG_RST), "clock cfg reset");
		rd(ADDR_POW_CFG, 32'(POW_CFG_RST), "power cfg reset");
		rd(ADDR_CLK_KEY1, 32'h0, "key readback");
		rd(32'hFFFF0500, 32'h0, "unmapped read");
		chk(32'({ext_clk_select, pll_ref_internal}), 32'h1, "reset source");
		chk(32'(mult), 32'd1275, "multiplier");
	endtask
	task automatic t_keys;
		clkc(32'hFF);
		rd(ADDR_CLK_CFG, 32'h23, "keyed clock write");
		chk(32'(ext_clk_select), 32'h0, "held until nap");
		prot(ADDR_CLK_KEY1, 32'hAB, ADDR_CLK_CFG, 32'h21, ADDR_CLK_KEY2, 32'h55);
		rd(ADDR_CLK_CFG, 32'h23, "bad first key");
		prot(ADDR_POW_KEY1, 32'h01, ADDR_POW_CFG, 32'h10, ADDR_POW_KEY2, 32'hF5);
		prot(ADDR_CLK_KEY1, 32'hAA, ADDR_POW_CFG, 32'h10, ADDR_POW_KEY2, 32'hF4);
		rd(ADDR_POW_CFG, 32'h03, "bad power keys");
		wr(ADDR_CLK_KEY1, 32'hAA);
		wr(32'hFFFF0500, 32'h0);
		wr(ADDR_CLK_CFG, 32'h01);
		wr(ADDR_CLK_KEY2, 32'h55);
		idle(2);
		rd(ADDR_CLK_CFG, 32'h23, "broken sequence");
		rd(ADDR_IRQ_STAT, 32'h4, "key fault flag");
		chk(32'(irq), 32'h0, "masked fault");
		wr(ADDR_IRQ_MASK, 32'h4);
		idle(1);
		chk(32'(irq), 32'h1, "unmasked fault");
		wr(ADDR_IRQ_STAT, 32'h4);
		wr(ADDR_IRQ_MASK, 32'h0);
		idle(1);
		chk(32'(irq), 32'h0, "fault cleared");
		clkc(32'h21);
	endtask
	task automatic t_div;
		int c;
		for (int d = 0; d < 8; d++) begin
			pow(32'(d));
			rd(ADDR_POW_CFG, 32'(d), "divider readback");
			cnt_en(256, c);
			chk(32'(c), 32'(256 >> d), "core clock rate");
		end
	endtask
	task automatic t_modes;
		int md [7] = '{1, 2, 3, 3, 3, 3, 4};
		int sr [7] = '{5, 5, 4, 0, 1, 2, 3};
		int lm [7] = '{5, 5, SLP, SLP, SLP, SLP, STP};
		logic [4:0] ex [4] = '{5'h0F, 5'h07, 5'h03, 5'h01};
		for (int i = 0; i < 7; i++) begin
			pow(32'(md[i] << 4));
			chk(32'({core_run, periph_run, pll_run, xtal_timer_run, ext_irq_run}), 32'(ex[md[i]-1]), "run");
			rd(ADDR_POW_CFG, 32'(md[i] << 4), "mode readback");
			if (md[i] == 4) begin
				@(posedge clk_sys);
				wake_tmr <= 1'b1;
				repeat (STP + 10) @(posedge clk_sys);
				wake_tmr <= 1'b0;
				#1;
				chk(32'(core_run), 32'h0, "stop ignores timer");
			end
			wake_by(sr[i], lm[i]);
			rd(ADDR_POW_CFG, 32'h0, "active after wake");
			rd(ADDR_IRQ_STAT, 32'h2, "wake flag");
			wr(ADDR_IRQ_STAT, 32'h2);
		end
		// reserved mode codes must leave every domain running
		pow(32'h50);
		chk(32'({core_run, periph_run, pll_run, xtal_timer_run, ext_irq_run}), 32'h1F, "reserved mode runs");
		rd(ADDR_POW_CFG, 32'h50, "reserved mode readback");
		pow(32'h0);
	endtask
	task automatic t_src;
		clkc(32'h23);
		pow(32'(MODE_NAP) << 4);
		chk(32'({ext_clk_select, pll_ref_internal}), 32'h3, "pin source in nap");
		rd(ADDR_STATUS, 32'h0F, "status in nap");
		wake_by(5, 5);
		clkc(32'h01);
		pow(32'(MODE_NAP) << 4);
		chk(32'({ext_clk_select, pll_ref_internal}), 32'h0, "crystal reference");
		wake_by(5, 5);
		// a reserved source code is stored but the applied source stays put
		clkc(32'h22);
		pow(32'(MODE_NAP) << 4);
		chk(32'({ext_clk_select, pll_ref_internal}), 32'h1, "reserved source kept");
		wake_by(5, 5);
	endtask
	task automatic t_lock;
		int c;
		wr(ADDR_IRQ_MASK, 32'h1);
		idle(1);
		@(posedge clk_sys);
		pll_lock <= 1'b0;
		repeat (8) @(posedge clk_sys);
		cnt_en(32, c);
		chk(32'(c), 32'h0, "core halted");
		chk(32'({pll_irq_req, irq}), 32'h0, "held while unlocked");
		@(posedge clk_sys);
		pll_lock <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		chk(32'({pll_irq_req, irq}), 32'h3, "served after relock");
		cnt_en(64, c);
		chk(32'(c), 32'd64, "core resumes");
		wr(ADDR_IRQ_STAT, 32'h1);
		idle(2);
		chk(32'({pll_irq_req, irq}), 32'h0, "lock flag cleared");
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (8) @(posedge clk_sys);
		t_reset;
		$display("reset test done");
		t_keys;
		$display("key test done");
		t_div;
		$display("divider test done");
		t_modes;
		$display("mode test done");
		t_src;
		$display("source test done");
		t_lock;
		$display("lock test done");
		end_of_test;
	end
endmodule
bind ckpm_ctrl ckpm_ctrl_asserts ckpm_ctrl_asserts_inst (
	.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .pll_lock, .core_clk_en, .core_run, .periph_run,
	.pll_run, .xtal_timer_run, .ext_irq_run, .ext_clk_select, .pll_ref_internal, .pll_multiplier, .pll_irq_req
);
